// [bsasl_ack_judge.v]
`include "bsasl_regs.vh"

module bsasl_ack_judge (
    // Field under judgement
    input  wire [2:0] kind,
    input  wire [3:0] code,
    input  wire       curCode3,
    input  wire       parErr,
    input  wire       masterParErr,
    input  wire       timingErr,
    input  wire       addrMatch,
    input  wire       bcast,
    // Device state
    input  wire       rxEnable,
    input  wire       txEnable,
    input  wire       locked,
    input  wire       otherMaster,
    input  wire       rxFull,
    // Verdict
    output reg        nack
);

    reg undefCode;
    reg lockGuarded;

    always @* begin
        undefCode   = 1'h0;
        lockGuarded = 1'h0;
        nack        = 1'h0;
        case (code)
            `BSASL_CC_STATUS, `BSASL_CC_LADDR_LO, `BSASL_CC_LADDR_HI,
            `BSASL_CC_WRCMD, `BSASL_CC_WRDATA, `BSASL_CC_RDLOCK,
            `BSASL_CC_STUNLOCK, `BSASL_CC_RDDATA, `BSASL_CC_WRCMDLK,
            `BSASL_CC_WRDATLK: undefCode = 1'h0;
            default: undefCode = 1'h1;
        endcase
        lockGuarded = (code == `BSASL_CC_RDLOCK) | (code == `BSASL_CC_STUNLOCK) |
                      (code == `BSASL_CC_RDDATA) | (code == `BSASL_CC_WRCMDLK) |
                      (code == `BSASL_CC_WRDATLK) | (code == `BSASL_CC_WRCMD) |
                      (code == `BSASL_CC_WRDATA);
        case (kind)
            `BSASL_FK_SADDR: nack = parErr | masterParErr | timingErr | ~addrMatch;
            `BSASL_FK_CTRL: begin
                nack = parErr | timingErr | undefCode;
                if (code[`BSASL_CC_WRITE_BIT] & ~rxEnable & ~bcast) begin
                    nack = 1'h1;
                end
                if (((code == `BSASL_CC_RDLOCK) | (code == `BSASL_CC_RDDATA)) & ~txEnable) begin
                    nack = 1'h1;
                end
                if (locked & otherMaster & lockGuarded) begin
                    nack = 1'h1;
                end
                if (((code == `BSASL_CC_LADDR_LO) | (code == `BSASL_CC_LADDR_HI)) & ~locked) begin
                    nack = 1'h1;
                end
            end
            `BSASL_FK_LEN: nack = parErr | timingErr;
            `BSASL_FK_DATA: nack = parErr | timingErr | (curCode3 & rxFull) |
                                   (locked & otherMaster);
            default: nack = 1'h0;
        endcase
    end

endmodule // bsasl_ack_judge

// [bsasl_ahb_slave.v]
`include "bsasl_regs.vh"

module bsasl_ahb_slave (
    // Clock and reset
    input  wire        clk,
    input  wire        rst_b,
    // AHB-Lite slave side
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    // Register strobes
    output wire        rdStrobe,
    output wire [7:0]  rdOff,
    output wire        wrStrobe,
    output wire [7:0]  wrOff
);

    reg        wrPend_ff;
    reg [7:0]  wrOff_ff;
    reg        readyOut_ff;
    wire       addrPhase;

    ////////////////////////////////////////////////////////////////////////////
    // Zero wait states; only word access is meaningful, low bits ignored
    assign addrPhase = hsel & hready & (htrans[1] == 1'h1);
    assign rdStrobe  = addrPhase & ~hwrite;
    assign rdOff     = {haddr[7:2], 2'h0};
    assign wrStrobe  = wrPend_ff;
    assign wrOff     = wrOff_ff;
    assign hreadyout = readyOut_ff;
    assign hresp     = 1'h0;

    // Write data arrive one cycle after the address phase
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wrPend_ff   <= 1'h0;
            wrOff_ff    <= 8'h00;
            readyOut_ff <= 1'h0;
        end else begin
            readyOut_ff <= 1'h1;
            wrPend_ff   <= addrPhase & hwrite;
            if (addrPhase & hwrite) begin
                wrOff_ff <= {haddr[7:2], 2'h0};
            end
        end
    end

endmodule // bsasl_ahb_slave

// [bsasl_far_unit.sv]
module bsasl_far_unit (
    input  logic        clk,
    output logic        fieldValid, fieldParity, timingErr, broadcast,
    output logic        addrMatch, txAcked, frameEnd,
    output logic [2:0]  fieldKind,
    output logic [11:0] fieldData
);
    timeunit 1ns;
    timeprecision 100ps;
    // clean bit timing, every field carries parity
    initial {fieldValid, fieldParity, timingErr, broadcast, txAcked, frameEnd} = 6'h00;
    initial {addrMatch, fieldKind, fieldData} = 16'h8000;
    task field(input logic [2:0] k, input logic [11:0] d, input logic pe);
        @(posedge clk);
        fieldValid <= 1'b1;
        fieldKind  <= k;
        fieldData  <= d;
        fieldParity <= ^d ^ pe;
        @(posedge clk);
        fieldValid  <= 1'b0;
        // Released lines must not keep the old value
        fieldData   <= ~d;
        fieldParity <= ~(^d ^ pe);
    endtask
    task set_bcast(input logic b);
        broadcast <= b;
    endtask
    task terr;
        @(posedge clk);
        timingErr <= 1'b1;
        @(posedge clk);
        timingErr <= 1'b0;
    endtask
    task pulse(input logic t);
        @(posedge clk);
        txAcked  <= t;
        frameEnd <= !t;
        @(posedge clk);
        txAcked  <= 1'b0;
        frameEnd <= 1'b0;
    endtask
endmodule // bsasl_far_unit

// [bsasl_regs.vh]
`ifndef BSASL_REGS_VH
`define BSASL_REGS_VH

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets
`define BSASL_OFF_CTRL      8'h00
`define BSASL_OFF_STATUS    8'h04
`define BSASL_OFF_DATA      8'h08
`define BSASL_OFF_LOCKADDR  8'h0C

// Control register fields
`define BSASL_CTRL_RXEN     3
`define BSASL_CTRL_TXEN     4

// Slave status byte layout
`define BSASL_ST_TXWR       0
`define BSASL_ST_RXFULL     1
`define BSASL_ST_LOCKED     2
`define BSASL_ST_TXRDY      4
`define BSASL_ST_MODE_HI    7
`define BSASL_ST_MODE_LO    6
`define BSASL_MODE_CODE     2'h1
`define BSASL_TXWR_RST      1'h1

// Field kinds from the field sequencer
`define BSASL_FK_MADDR      3'h0
`define BSASL_FK_SADDR      3'h1
`define BSASL_FK_CTRL       3'h2
`define BSASL_FK_LEN        3'h3
`define BSASL_FK_DATA       3'h4

// Control codes
`define BSASL_CC_STATUS     4'h0
`define BSASL_CC_RDLOCK     4'h3
`define BSASL_CC_LADDR_LO   4'h4
`define BSASL_CC_LADDR_HI   4'h5
`define BSASL_CC_STUNLOCK   4'h6
`define BSASL_CC_RDDATA     4'h7
`define BSASL_CC_WRCMDLK    4'hA
`define BSASL_CC_WRDATLK    4'hB
`define BSASL_CC_WRCMD      4'hE
`define BSASL_CC_WRDATA     4'hF
`define BSASL_CC_WRITE_BIT  3

// Length field: zero means the full count
`define BSASL_LEN_FULL      9'h100

// AHB encodings
`define BSASL_HTRANS_NONSEQ 2'h2
`define BSASL_HTRANS_SEQ    2'h3

`endif

// [bsasl_top.v]
`include "bsasl_regs.vh"

// Functional notes
// - Parity bit is one when the protected bits hold an odd count.
// - Every address, control, length and data byte carries a parity bit.
// - Individual frames acknowledge slave address, control, length and each data byte the master writes.
// - Acknowledge zero accepts, one refuses; broadcast acknowledges are ignored.
// - Slave address refused on address parity, timing error or no address match.
// - Control refused on parity, timing error or undefined code.
// - Write codes refused in individual frames while slave receive is disabled.
// - Data read codes refused while slave transmit is disabled.
// - While locked, foreign masters get guarded codes refused and no data accepted.
// - Lock address read refused when not locked.
// - Receive disable stops individual frames only; broadcast keeps receiving.
// - Length refused on parity or timing error.
// - Data refused on parity, timing error or unread byte in data register.
// - Status bit 0 shows transmit data written; reset sets it.
// - Status bit 1 receive data held, bit 2 locked, bits 3 and 5 zero.
// - Status bit 4 mirrors slave transmit enable.
// - Status bits 7 and 6 always report mode 1.
// - Lock address read returns locking master's 12-bit address in bytes.
// - Individual locking frame ending short after acked length sets lock.
// - Completed locking or unlock code frame clears lock.
// - Broadcast never sets lock; codes 0,4,5,E,F never lock.
// - Timing error outside master address and read data fields aborts the transfer and returns to standby.
// - Locking master unlocks via 3,6,A,B individual or A,B broadcast completion.
module bsasl_top #(
    parameter ADDR_W = 12,
    parameter BYTE_W = 8
) (
    // Clock and reset
    input  wire              clk,
    input  wire              rst_b,
    // AHB-Lite register bus
    input  wire              hsel,
    input  wire [31:0]       haddr,
    input  wire [1:0]        htrans,
    input  wire              hwrite,
    input  wire [2:0]        hsize,
    input  wire [31:0]       hwdata,
    input  wire              hready,
    output wire              hreadyout,
    output wire              hresp,
    output wire [31:0]       hrdata,
    // Field sequencer in
    input  wire              fieldValid,
    input  wire [2:0]        fieldKind,
    input  wire [ADDR_W-1:0] fieldData,
    input  wire              fieldParity,
    input  wire              timingErr,
    input  wire              broadcast,
    input  wire              addrMatch,
    input  wire              txAcked,
    input  wire              frameEnd,
    // Field sequencer out
    output wire              ackValid,
    output wire              ackNack,
    output wire              abortXfer,
    output wire [BYTE_W-1:0] txByte,
    output wire              txParity,
    // Events
    output wire              dataRequestIrq,
    output wire              transferEndIrq
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    reg [31:0]       hrdata_ff;
    reg              slaveRxEnable_ff;
    reg              slaveTxEnable_ff;
    reg [BYTE_W-1:0] busDataReg_ff;
    reg              txWritten_ff;
    reg              rxFull_ff;
    reg              locked_ff;
    reg [ADDR_W-1:0] lockAddr_ff;
    reg [ADDR_W-1:0] masterAddr_ff;
    reg              masterParErr_ff;
    reg              frameBcast_ff;
    reg [3:0]        ctrlCode_ff;
    reg              lenAcked_ff;
    reg [8:0]        lenBytes_ff;
    reg [8:0]        moved_ff;
    reg              ackValid_ff;
    reg              ackNack_ff;
    reg              abortXfer_ff;
    reg [BYTE_W-1:0] txByte_ff;
    reg              txParity_ff;
    reg              dataRequestIrq_ff;
    reg              transferEndIrq_ff;

    reg [31:0]       nxt_hrdata;
    reg [BYTE_W-1:0] nxt_txByte;

    wire             rdStrobe;
    wire [7:0]       rdOff;
    wire             wrStrobe;
    wire [7:0]       wrOff;
    wire             nack;
    wire             parErr;
    wire             otherMaster;
    wire             sameMaster;
    wire [7:0]       slaveStatus;
    wire             fieldIsData;
    wire             rxTake;
    wire             swReadData;
    wire             swWriteData;
    wire             allDone;
    wire             lockCode;
    wire             setLock;
    wire             clearLock;

    ////////////////////////////////////////////////////////////////////////////
    // Functions

    function evenParity;
        input [ADDR_W-1:0] bits;
        begin
            evenParity = ^bits;
        end
    endfunction

    function [8:0] lenCount;
        input [7:0] lenField;
        begin
            if (lenField == 8'h00) begin
                lenCount = `BSASL_LEN_FULL;
            end else begin
                lenCount = {1'h0, lenField};
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Register bus slave
    bsasl_ahb_slave u_ahb (
        .clk       (clk),
        .rst_b     (rst_b),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hready    (hready),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .rdStrobe  (rdStrobe),
        .rdOff     (rdOff),
        .wrStrobe  (wrStrobe),
        .wrOff     (wrOff)
    );

    // Size is not checked; only whole-word transfers are issued
    assign swReadData  = rdStrobe & (rdOff == `BSASL_OFF_DATA);
    assign swWriteData = wrStrobe & (wrOff == `BSASL_OFF_DATA);

    assign slaveStatus = {`BSASL_MODE_CODE, 1'h0, slaveTxEnable_ff, 1'h0,
                          locked_ff, rxFull_ff, txWritten_ff};

    always @* begin
        nxt_hrdata = 32'h0000_0000;
        case (rdOff)
            `BSASL_OFF_CTRL: begin
                nxt_hrdata[`BSASL_CTRL_RXEN] = slaveRxEnable_ff;
                nxt_hrdata[`BSASL_CTRL_TXEN] = slaveTxEnable_ff;
            end
            `BSASL_OFF_STATUS:   nxt_hrdata[7:0] = slaveStatus;
            `BSASL_OFF_DATA:     nxt_hrdata[BYTE_W-1:0] = busDataReg_ff;
            `BSASL_OFF_LOCKADDR: nxt_hrdata[ADDR_W-1:0] = lockAddr_ff;
            default:             nxt_hrdata = 32'h0000_0000;
        endcase
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hrdata_ff        <= 32'h0000_0000;
            slaveRxEnable_ff <= 1'h0;
            slaveTxEnable_ff <= 1'h0;
        end else begin
            if (rdStrobe) begin
                hrdata_ff <= nxt_hrdata;
            end
            if (wrStrobe & (wrOff == `BSASL_OFF_CTRL)) begin
                slaveRxEnable_ff <= hwdata[`BSASL_CTRL_RXEN];
                slaveTxEnable_ff <= hwdata[`BSASL_CTRL_TXEN];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Acknowledge decision

    assign parErr      = evenParity(fieldData) != fieldParity;
    assign sameMaster  = masterAddr_ff == lockAddr_ff;
    assign otherMaster = ~sameMaster;
    assign fieldIsData = fieldKind == `BSASL_FK_DATA;

    bsasl_ack_judge u_judge (
        .kind         (fieldKind),
        .code         (fieldData[3:0]),
        .curCode3     (ctrlCode_ff[`BSASL_CC_WRITE_BIT]),
        .parErr       (parErr),
        .masterParErr (masterParErr_ff),
        .timingErr    (timingErr),
        .addrMatch    (addrMatch),
        .bcast        (frameBcast_ff),
        .rxEnable     (slaveRxEnable_ff),
        .txEnable     (slaveTxEnable_ff),
        .locked       (locked_ff),
        .otherMaster  (otherMaster),
        .rxFull       (rxFull_ff),
        .nack         (nack)
    );

    // Only bytes the master writes are taken into the data register here
    assign rxTake = fieldValid & fieldIsData & ctrlCode_ff[`BSASL_CC_WRITE_BIT] & ~nack;

    ////////////////////////////////////////////////////////////////////////////
    // Frame tracking and acknowledge output
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            masterAddr_ff     <= {ADDR_W{1'h0}};
            masterParErr_ff   <= 1'h0;
            frameBcast_ff     <= 1'h0;
            ctrlCode_ff       <= 4'h0;
            lenAcked_ff       <= 1'h0;
            lenBytes_ff       <= 9'h000;
            moved_ff          <= 9'h000;
            ackValid_ff       <= 1'h0;
            ackNack_ff        <= 1'h0;
            abortXfer_ff      <= 1'h0;
            dataRequestIrq_ff <= 1'h0;
        end else begin
            ackValid_ff       <= 1'h0;
            ackNack_ff        <= 1'h0;
            abortXfer_ff      <= 1'h0;
            dataRequestIrq_ff <= 1'h0;
            if (fieldValid) begin
                case (fieldKind)
                    `BSASL_FK_MADDR: begin
                        masterAddr_ff   <= fieldData;
                        masterParErr_ff <= parErr;
                        frameBcast_ff   <= broadcast;
                        ctrlCode_ff     <= 4'h0;
                        lenAcked_ff     <= 1'h0;
                        lenBytes_ff     <= 9'h000;
                        moved_ff        <= 9'h000;
                    end
                    `BSASL_FK_LEN: begin
                        lenBytes_ff <= lenCount(fieldData[7:0]);
                        lenAcked_ff <= ~nack;
                    end
                    `BSASL_FK_CTRL: begin
                        ctrlCode_ff <= fieldData[3:0];
                    end
                    default: begin
                        ctrlCode_ff <= ctrlCode_ff;
                    end
                endcase
                if (fieldKind != `BSASL_FK_MADDR) begin
                    if (!frameBcast_ff && (!fieldIsData || ctrlCode_ff[`BSASL_CC_WRITE_BIT])) begin
                        ackValid_ff <= 1'h1;
                        ackNack_ff  <= nack;
                    end
                    if (nack && (!fieldIsData || ctrlCode_ff[`BSASL_CC_WRITE_BIT])) begin
                        abortXfer_ff <= 1'h1;
                    end
                end
            end else if (timingErr) begin
                abortXfer_ff <= 1'h1;
            end
            if (rxTake) begin
                moved_ff          <= moved_ff + 9'h001;
                dataRequestIrq_ff <= 1'h1;
            end else if (txAcked) begin
                moved_ff <= moved_ff + 9'h001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Data register and its flags
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            busDataReg_ff <= {BYTE_W{1'h0}};
            txWritten_ff  <= `BSASL_TXWR_RST;
            rxFull_ff     <= 1'h0;
        end else begin
            if (rxTake) begin
                busDataReg_ff <= fieldData[BYTE_W-1:0];
            end else if (swWriteData) begin
                busDataReg_ff <= hwdata[BYTE_W-1:0];
            end
            if (swWriteData) begin
                txWritten_ff <= 1'h1;
            end else if (txAcked && ((ctrlCode_ff == `BSASL_CC_RDLOCK) ||
                                     (ctrlCode_ff == `BSASL_CC_RDDATA))) begin
                txWritten_ff <= 1'h0;
            end
            if (rxTake) begin
                rxFull_ff <= 1'h1;
            end else if (swReadData) begin
                rxFull_ff <= 1'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Lock state
    assign allDone  = lenAcked_ff & (moved_ff == lenBytes_ff);
    // only 3, A, B can lock
    assign lockCode = (ctrlCode_ff == `BSASL_CC_RDLOCK) |
                      (ctrlCode_ff == `BSASL_CC_WRCMDLK) |
                      (ctrlCode_ff == `BSASL_CC_WRDATLK);
    assign setLock  = ~frameBcast_ff & lenAcked_ff & lockCode & ~allDone &
                      (~locked_ff | sameMaster);
    assign clearLock = locked_ff & sameMaster & allDone &
                       ((~frameBcast_ff & (lockCode | (ctrlCode_ff == `BSASL_CC_STUNLOCK))) |
                        (frameBcast_ff & ((ctrlCode_ff == `BSASL_CC_WRCMDLK) |
                                          (ctrlCode_ff == `BSASL_CC_WRDATLK))));

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            locked_ff         <= 1'h0;
            lockAddr_ff       <= {ADDR_W{1'h0}};
            transferEndIrq_ff <= 1'h0;
        end else begin
            transferEndIrq_ff <= frameEnd;
            if (frameEnd) begin
                if (setLock) begin
                    locked_ff   <= 1'h1;
                    lockAddr_ff <= masterAddr_ff;
                end else if (clearLock) begin
                    locked_ff <= 1'h0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmit byte for master reads
    always @* begin
        nxt_txByte = {BYTE_W{1'h0}};
        case (ctrlCode_ff)
            `BSASL_CC_STATUS, `BSASL_CC_STUNLOCK: nxt_txByte = slaveStatus;
            `BSASL_CC_RDLOCK, `BSASL_CC_RDDATA:   nxt_txByte = busDataReg_ff;
            `BSASL_CC_LADDR_LO: nxt_txByte = lockAddr_ff[7:0];
            `BSASL_CC_LADDR_HI: nxt_txByte = {4'h0, lockAddr_ff[ADDR_W-1:8]};
            default:            nxt_txByte = {BYTE_W{1'h0}};
        endcase
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            txByte_ff   <= {BYTE_W{1'h0}};
            txParity_ff <= 1'h0;
        end else begin
            txByte_ff   <= nxt_txByte;
            txParity_ff <= evenParity({{(ADDR_W-BYTE_W){1'h0}}, nxt_txByte});
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign hrdata         = hrdata_ff;
    assign ackValid       = ackValid_ff;
    assign ackNack        = ackNack_ff;
    assign abortXfer      = abortXfer_ff;
    assign txByte         = txByte_ff;
    assign txParity       = txParity_ff;
    assign dataRequestIrq = dataRequestIrq_ff;
    assign transferEndIrq = transferEndIrq_ff;

endmodule // bsasl_top

// [bsasl_top_assertions.sv]
module bsasl_chk #(
    parameter ADDR_W = 12,
    parameter BYTE_W = 8
) (
    // Clock and reset
    input logic              clk, rst_b,
    // Field link in
    input logic              fieldValid, fieldParity, frameEnd,
    input logic [2:0]        fieldKind,
    input logic [ADDR_W-1:0] fieldData,
    // Replies
    input logic              ackValid, ackNack, abortXfer,
    input logic              txParity, transferEndIrq, dataRequestIrq,
    input logic [BYTE_W-1:0] txByte
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic bad;
    // Upper field bits are zero, so full width parity is safe
    assign bad = fieldParity != ^fieldData;
    ////////////////////////////////////////////////////////////////////////
    chk_ack_cause: assert property (ackValid |-> $past(fieldValid))
        else $error("ack without a field");
    chk_nack_abort: assert property (ackValid && ackNack |-> abortXfer)
        else $error("nack without abort");
    chk_ctrl_par: assert property (fieldValid && fieldKind == 3'h2 && bad |=> !ackValid || ackNack)
        else $error("bad control parity accepted");
    chk_len_par: assert property (fieldValid && fieldKind == 3'h3 && bad |=> !ackValid || ackNack)
        else $error("bad length parity accepted");
    chk_data_par: assert property (fieldValid && fieldKind == 3'h4 && bad |=> !ackValid || ackNack)
        else $error("bad data parity accepted");
    chk_tx_par: assert property (txParity == ^txByte)
        else $error("tx parity not even");
    chk_end_irq: assert property (frameEnd |=> transferEndIrq)
        else $error("end event missing");
    chk_store_irq: assert property (dataRequestIrq |-> $past(fieldValid && fieldKind == 3'h4))
        else $error("store event without data");
    cover property (ackValid && !ackNack);
    cover property (ackValid && ackNack);
    cover property (dataRequestIrq);
endmodule // bsasl_chk

// [bsasl_top_tb.sv]
`include "bsasl_regs.vh"
module bsasl_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, rst_b = 0, hsel = 0, hwrite = 0, hready;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, v;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2, fieldKind;
    logic [11:0] fieldData;
    logic [7:0] txByte;
    logic fieldValid, fieldParity, timingErr, broadcast, addrMatch, txAcked, frameEnd;
    logic hreadyout, hresp, ackValid, ackNack, abortXfer, txParity;
    logic dataRequestIrq, transferEndIrq;
    int n_mismatch = 0, n_tests = 0;
    assign hready = hreadyout;
    always #5 clk = ~clk;
    bsasl_top i_bsasl_top (.clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hreadyout, .hresp, .hrdata, .fieldValid, .fieldKind, .fieldData,
        .fieldParity, .timingErr, .broadcast, .addrMatch, .txAcked, .frameEnd, .ackValid,
        .ackNack, .abortXfer, .txByte, .txParity, .dataRequestIrq, .transferEndIrq);
    bsasl_far_unit i_bsasl_far_unit (.clk, .fieldValid, .fieldParity, .timingErr,
        .broadcast, .addrMatch, .txAcked, .frameEnd, .fieldKind, .fieldData);
    ////////////////////////////////////////////////////////////////////////
    task close_out;
        if (n_mismatch == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            n_mismatch++;
            $display("ERROR %0t: got %h want %h", $time, s, e);
        end
    endtask
    // Bounded wait for hready at a rising edge
    task rdy;
        int i;
        @(posedge clk);
        for (i = 0; hready !== 1'b1; i++) begin
            if (i > 50) begin
                n_mismatch++;
                close_out;
            end
            @(posedge clk);
        end
    endtask
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        haddr  <= {24'h0, a};
        htrans <= `BSASL_HTRANS_NONSEQ;
        hwrite <= w;
        hsel   <= 1'b1;
        rdy;
        htrans <= 2'h0;
        hwdata <= wd;
        rdy;
        v = hrdata;
    endtask
    task fa(input logic [2:0] k, input logic [11:0] d, input logic pe, input logic e);
        i_bsasl_far_unit.field(k, d, pe);
        #1;
        chk({ackValid, ackNack, abortXfer}, {1'b1, e, e});
    endtask
    // Master address, slave address, control with its verdict
    task hdr(input logic [11:0] m, input logic [3:0] c, input logic pe, input logic e);
        i_bsasl_far_unit.field(`BSASL_FK_MADDR, m, 1'b0);
        fa(`BSASL_FK_SADDR, 12'h0AB, 1'b0, 1'b0);
        fa(`BSASL_FK_CTRL, {8'h0, c}, pe, e);
    endtask
    task endf;
        i_bsasl_far_unit.pulse(1'b0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        ahb(0, `BSASL_OFF_STATUS, 0);
        chk(v, 32'h41);
        hdr(12'h123, 4'hF, 0, 1);
        endf;
        ahb(1, `BSASL_OFF_CTRL, 32'h18);
        ahb(0, `BSASL_OFF_STATUS, 0);
        chk(v, 32'h51);
        hdr(12'h123, 4'hF, 1, 1);
        endf;
        hdr(12'h123, 4'hF, 0, 0);
        fa(`BSASL_FK_LEN, 12'h002, 1, 1);
        endf;
        hdr(12'h123, 4'hF, 0, 0);
        fa(`BSASL_FK_LEN, 12'h001, 0, 0);
        fa(`BSASL_FK_DATA, 12'h011, 1, 1);
        endf;
        // Short locking frame, second byte hits the full register
        hdr(12'h123, 4'hA, 0, 0);
        fa(`BSASL_FK_LEN, 12'h002, 0, 0);
        fa(`BSASL_FK_DATA, 12'h05A, 0, 0);
        fa(`BSASL_FK_DATA, 12'h0A5, 0, 1);
        fa(`BSASL_FK_DATA, 12'h0A5, 0, 1);
        endf;
        ahb(0, `BSASL_OFF_STATUS, 0);
        chk(v, 32'h57);
        ahb(0, `BSASL_OFF_DATA, 0);
        chk(v, 32'h5A);
        ahb(0, `BSASL_OFF_LOCKADDR, 0);
        chk(v, 32'h123);
        hdr(12'h321, 4'hF, 0, 1);
        endf;
        hdr(12'h123, 4'h4, 0, 0);
        @(posedge clk);
        #1;
        chk(txByte, 8'h23);
        endf;
        hdr(12'h123, 4'h6, 0, 0);
        i_bsasl_far_unit.field(`BSASL_FK_LEN, 12'h001, 1'b0);
        i_bsasl_far_unit.pulse(1'b1);
        endf;
        ahb(0, `BSASL_OFF_STATUS, 0);
        chk(v, 32'h51);
        hdr(12'h123, 4'h4, 0, 1);
        endf;
        i_bsasl_far_unit.terr;
        #1;
        chk({ackValid, abortXfer}, 2'b01);
        // Broadcast short locking write, receive disabled
        ahb(1, `BSASL_OFF_CTRL, 32'h10);
        i_bsasl_far_unit.set_bcast(1'b1);
        i_bsasl_far_unit.field(`BSASL_FK_MADDR, 12'h123, 1'b0);
        i_bsasl_far_unit.field(`BSASL_FK_SADDR, 12'h0AB, 1'b0);
        i_bsasl_far_unit.field(`BSASL_FK_CTRL, 12'h00A, 1'b0);
        #1;
        chk({ackValid, abortXfer}, 2'b00);
        i_bsasl_far_unit.field(`BSASL_FK_LEN, 12'h002, 1'b0);
        i_bsasl_far_unit.field(`BSASL_FK_DATA, 12'h05A, 1'b0);
        #1;
        chk({ackValid, dataRequestIrq}, 2'b01);
        endf;
        i_bsasl_far_unit.set_bcast(1'b0);
        ahb(0, `BSASL_OFF_STATUS, 0);
        chk(v, 32'h53);
        close_out;
    end
endmodule // bsasl_top_tb
bind bsasl_top bsasl_chk #(.ADDR_W(ADDR_W), .BYTE_W(BYTE_W)) i_bsasl_chk (.clk, .rst_b,
    .fieldValid, .fieldParity, .frameEnd, .fieldKind, .fieldData, .ackValid, .ackNack,
    .abortXfer, .txParity, .transferEndIrq, .dataRequestIrq, .txByte);
